// [siot_defs.vh]
// Constants for the safety I/O status and test-pulse block.
// Assumes a 25 MHz module clock and a plain register port.
// What this block does
// - Off is the safe state: safety outputs off, input data to network off.
// - Self-diagnostics run once after power-up and then periodically.
// - A fatal fault lights the health lamp red and forces all data off.
// - Every point status bit reads one for on or normal, zero for fault.
// - Each input, output and test output has status; outputs have readback.
// - Combined input and output status are the AND of the point status.
// - After a fatal fault the controller cannot rely on status delivery.
// - Each test output can be a pulse source bound to one safety input.
// - Pulse and supply test outputs run from power-up, link or not.
// - A test output in standard mode follows the controller command.
// - A test output in supply mode is held on without pulsing.
// - Pulse mode gives a 500 us off-going pulse every 150 ms.
// - Verified configuration can be locked against change until unlocked.
// - Test pulses are emitted whether the input contact is open or closed.
// - A wiring fault forces that input's data and status bits off.
`ifndef SIOT_DEFS_VH
`define SIOT_DEFS_VH
// Timing
`define SIOT_CLK_MHZ 25
`define SIOT_PULSE_US 500
`define SIOT_PERIOD_MS 150
`define SIOT_DIAG_MS 100
// Register index (address)
`define SIOT_A_CTRL 4'h0
`define SIOT_A_TMODE 4'h1
`define SIOT_A_TASSOC 4'h2
`define SIOT_A_CMD 4'h3
`define SIOT_A_IN_DATA 4'h4
`define SIOT_A_IN_STAT 4'h5
`define SIOT_A_OUT_STAT 4'h6
`define SIOT_A_READBACK 4'h7
`define SIOT_A_IRQ_STAT 4'h8
`define SIOT_A_IRQ_MASK 4'h9
// CTRL fields
`define SIOT_CTRL_LOCK 0
`define SIOT_CTRL_DIAG_OK 1
`define SIOT_CTRL_FATAL 2
// Test output modes, 2 bits per point
`define SIOT_TM_STD 2'h0
`define SIOT_TM_PULSE 2'h1
`define SIOT_TM_SUPPLY 2'h2
// Interrupt status bits
`define SIOT_EV_IN_FAULT 0
`define SIOT_EV_OUT_FAULT 1
`define SIOT_EV_FATAL 2
`define SIOT_EV_DIAG 3
`define SIOT_EV_W 4
`endif

// [siot_top.v]
// Safety state, point status and test-pulse logic of a safety I/O module.
// Assumes pins arrive unsynchronised and a register port on ref_clk_i.
`timescale 1ns/1ps
`include "siot_defs.vh"
module siot_top #(
   parameter N_IN = 8,
   parameter N_OUT = 4,
   parameter N_TEST = 4,
   parameter AW_IN = 3,
   parameter CW = 22,
   parameter PULSE_CYC = `SIOT_PULSE_US * `SIOT_CLK_MHZ,
   parameter PERIOD_CYC = `SIOT_PERIOD_MS * 1000 * `SIOT_CLK_MHZ,
   parameter DIAG_CYC = `SIOT_DIAG_MS * 1000 * `SIOT_CLK_MHZ
) (
   // Clock, reset, enable
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire ce_i,
   // Register port
   input wire [3:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [15:0] rdata_o,
   // Field pins
   input wire [N_IN-1:0] in_pin_i,
   input wire [N_OUT-1:0] out_fb_i,
   input wire [N_TEST-1:0] test_fb_i,
   input wire diag_err_i,
   output reg [N_OUT-1:0] safe_out_o,
   output reg [N_TEST-1:0] test_out_o,
   // Lamp and interrupt
   output reg lamp_red_o,
   output reg lamp_green_o,
   output reg irq_o
);
   // Diagnostic state machine, one-hot
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_CHECK = 3'h2;
   localparam [2:0] ST_FAIL = 3'h4;
   reg [N_IN-1:0] in_s1_q, in_q;
   reg [N_OUT-1:0] ofb_s1_q, ofb_q;
   reg [N_TEST-1:0] tfb_s1_q, tfb_q;
   reg err_s1_q, err_q;
   reg lock_q;
   reg [2*N_TEST-1:0] tmode_q, tmode_sh_q;
   reg [AW_IN*N_TEST-1:0] tassoc_q, tassoc_sh_q;
   reg [N_OUT-1:0] out_cmd_q;
   reg [N_TEST-1:0] test_cmd_q;
   reg [N_OUT-1:0] out_d1_q, out_d2_q;
   reg [N_TEST-1:0] tst_d1_q, tst_d2_q;
   reg [N_IN-1:0] in_flt_q, in_data_q, in_stat_q;
   reg [N_OUT-1:0] out_stat_q, rback_q;
   reg [N_TEST-1:0] test_stat_q;
   reg comb_in_q, comb_out_q;
   reg [CW-1:0] per_cnt_q;
   reg pulse_q, pulse_end_q;
   reg [2:0] st_q;
   reg [31:0] diag_cnt_q;
   reg diag_ok_q, fatal_q, diag_evt_q;
   reg [`SIOT_EV_W-1:0] irq_stat_q, irq_mask_q;
   reg [N_IN-1:0] flt_set;
   reg [N_TEST-1:0] test_d;
   reg [15:0] rd_d;
   wire [`SIOT_EV_W-1:0] ev;
   integer t, f;
   // Two-flop synchronisers for every pin input
   always @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         {in_q, in_s1_q} <= {2*N_IN{1'b0}};
         {ofb_q, ofb_s1_q} <= {2*N_OUT{1'b0}};
         {tfb_q, tfb_s1_q} <= {2*N_TEST{1'b0}};
         {err_q, err_s1_q} <= 2'h0;
      end
      else if (ce_i)
      begin
         {in_q, in_s1_q} <= {in_s1_q, in_pin_i};
         {ofb_q, ofb_s1_q} <= {ofb_s1_q, out_fb_i};
         {tfb_q, tfb_s1_q} <= {tfb_s1_q, test_fb_i};
         {err_q, err_s1_q} <= {err_s1_q, diag_err_i};
      end
   end
   // Free-running pulse timer, started by reset, not by the link
   always @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         per_cnt_q <= {CW{1'b0}};
         pulse_q <= 1'b0;
         pulse_end_q <= 1'b0;
      end
      else if (ce_i)
      begin
         if (per_cnt_q == PERIOD_CYC[CW-1:0] - 1'b1)
            per_cnt_q <= {CW{1'b0}};
         else
            per_cnt_q <= per_cnt_q + 1'b1;
         pulse_q <= (per_cnt_q < PULSE_CYC[CW-1:0]);
         pulse_end_q <= (per_cnt_q == PULSE_CYC[CW-1:0]);
      end
   end

   // Test output drive by mode; pulse and supply ignore link state
   always @*
   begin
      for (t = 0; t < N_TEST; t = t + 1)
      begin
         case (tmode_q[2*t +: 2])
            `SIOT_TM_PULSE: test_d[t] = ~pulse_q;
            `SIOT_TM_SUPPLY: test_d[t] = 1'b1;
            default: test_d[t] = test_cmd_q[t];
         endcase
      end
   end
   // Pulse check: at pulse end an input still high has a short
   always @*
   begin
      flt_set = {N_IN{1'b0}};
      for (f = 0; f < N_TEST; f = f + 1)
         if (tmode_q[2*f +: 2] == `SIOT_TM_PULSE && pulse_end_q &&
             in_q[tassoc_q[AW_IN*f +: AW_IN]])
            flt_set[tassoc_q[AW_IN*f +: AW_IN]] = 1'b1;
   end
   // Per-input fault latch, data and status
   genvar g;
   generate
      for (g = 0; g < N_IN; g = g + 1)
      begin : g_in
         always @(posedge ref_clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               in_flt_q[g] <= 1'b0;
               in_data_q[g] <= 1'b0;
               in_stat_q[g] <= 1'b0;
            end
            else if (ce_i)
            begin
               // Set wins; recovery needs the input back in safe state
               if (flt_set[g])
                  in_flt_q[g] <= 1'b1;
               else if (!in_q[g] && !pulse_q)
                  in_flt_q[g] <= 1'b0;
               in_data_q[g] <= in_q[g] & ~in_flt_q[g] & ~flt_set[g] &
                  ~fatal_q;
               in_stat_q[g] <= ~in_flt_q[g] & ~flt_set[g] &
                  ~fatal_q;
            end
         end
      end
   endgenerate
   // Outputs, readback and point status; fatal forces all off
   always @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         safe_out_o <= {N_OUT{1'b0}};
         test_out_o <= {N_TEST{1'b0}};
         {out_d2_q, out_d1_q} <= {2*N_OUT{1'b0}};
         {tst_d2_q, tst_d1_q} <= {2*N_TEST{1'b0}};
         out_stat_q <= {N_OUT{1'b0}};
         test_stat_q <= {N_TEST{1'b0}};
         rback_q <= {N_OUT{1'b0}};
         {comb_in_q, comb_out_q} <= 2'h0;
         {lamp_red_o, lamp_green_o} <= 2'h0;
      end
      else if (ce_i)
      begin
         safe_out_o <= fatal_q ? {N_OUT{1'b0}} : out_cmd_q;
         test_out_o <= fatal_q ? {N_TEST{1'b0}} : test_d;
         // Delay drive to line up with synchronised feedback
         {out_d2_q, out_d1_q} <= {out_d1_q, safe_out_o};
         {tst_d2_q, tst_d1_q} <= {tst_d1_q, test_out_o};
         out_stat_q <= fatal_q ? {N_OUT{1'b0}} :
            ~(out_d2_q ^ ofb_q);
         test_stat_q <= fatal_q ? {N_TEST{1'b0}} : ~(tst_d2_q ^ tfb_q);
         rback_q <= fatal_q ? {N_OUT{1'b0}} : ofb_q;
         // Gated by fatal so combined bits drop with the point bits
         comb_in_q <= ~fatal_q & (&in_stat_q);
         comb_out_q <= ~fatal_q & (&out_stat_q);
         lamp_red_o <= fatal_q;
         lamp_green_o <= ~fatal_q & diag_ok_q;
      end
   end
   // Self-diagnostics at power-up and after every DIAG_CYC idle cycles
   always @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_q <= ST_CHECK;
         diag_cnt_q <= 32'h00000000;
         diag_ok_q <= 1'b0;
         fatal_q <= 1'b0;
         diag_evt_q <= 1'b0;
      end
      else if (ce_i)
      begin
         diag_evt_q <= 1'b0;
         case (st_q)
            ST_IDLE:
            begin
               if (diag_cnt_q == DIAG_CYC - 1)
               begin
                  diag_cnt_q <= 32'h00000000;
                  st_q <= ST_CHECK;
               end
               else
                  diag_cnt_q <= diag_cnt_q + 32'h00000001;
            end
            ST_CHECK:
            begin
               // Config copies must agree and no internal error flagged
               diag_evt_q <= 1'b1;
               if (err_q || tmode_q != tmode_sh_q ||
                   tassoc_q != tassoc_sh_q)
               begin
                  fatal_q <= 1'b1;
                  diag_ok_q <= 1'b0;
                  st_q <= ST_FAIL;
               end
               else
               begin
                  diag_ok_q <= 1'b1;
                  st_q <= ST_IDLE;
               end
            end
            ST_FAIL: st_q <= ST_FAIL; // Held until reset
            default: st_q <= ST_FAIL;
         endcase
      end
   end

   // Configuration registers with lock; shadow copies for diagnostics
   always @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         lock_q <= 1'b0;
         {tmode_q, tmode_sh_q} <= {4*N_TEST{1'b0}};
         {tassoc_q, tassoc_sh_q} <= {2*AW_IN*N_TEST{1'b0}};
         out_cmd_q <= {N_OUT{1'b0}};
         test_cmd_q <= {N_TEST{1'b0}};
         irq_mask_q <= {`SIOT_EV_W{1'b0}};
      end
      else if (ce_i && wr_i)
      begin
         case (addr_i)
            `SIOT_A_CTRL:
               // Lock only after a passed check; unlock any time
               if (!wdata_i[`SIOT_CTRL_LOCK] || diag_ok_q)
                  lock_q <= wdata_i[`SIOT_CTRL_LOCK];
            `SIOT_A_TMODE:
               if (!lock_q)
               begin
                  tmode_q <= wdata_i[2*N_TEST-1:0];
                  tmode_sh_q <= wdata_i[2*N_TEST-1:0];
               end
            `SIOT_A_TASSOC:
               if (!lock_q)
               begin
                  tassoc_q <= wdata_i[AW_IN*N_TEST-1:0];
                  tassoc_sh_q <= wdata_i[AW_IN*N_TEST-1:0];
               end
            `SIOT_A_CMD:
            begin
               out_cmd_q <= wdata_i[N_OUT-1:0];
               test_cmd_q <= wdata_i[8 +: N_TEST];
            end
            `SIOT_A_IRQ_MASK: irq_mask_q <= wdata_i[`SIOT_EV_W-1:0];
            default: lock_q <= lock_q;
         endcase
      end
   end

   // Events: input fault set at pulse end, output fault present, fatal entry, diagnostic pass done
   assign ev = {diag_evt_q & ~fatal_q, diag_evt_q & fatal_q,
                ~comb_out_q & ~fatal_q, |flt_set};

   // Sticky status, write one to clear, set wins over clear
   always @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         irq_stat_q <= {`SIOT_EV_W{1'b0}};
         irq_o <= 1'b0;
      end
      else if (ce_i)
      begin
         if (wr_i && addr_i == `SIOT_A_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~wdata_i[`SIOT_EV_W-1:0]) | ev;
         else
            irq_stat_q <= irq_stat_q | ev;
         irq_o <= |(irq_stat_q & irq_mask_q);
      end
   end

   // Read mux; status groups read zero after a fatal fault
   always @*
   begin
      rd_d = 16'h0000;
      case (addr_i)
         `SIOT_A_CTRL: rd_d[2:0] = {fatal_q, diag_ok_q, lock_q};
         `SIOT_A_TMODE: rd_d[2*N_TEST-1:0] = tmode_q;
         `SIOT_A_TASSOC: rd_d[AW_IN*N_TEST-1:0] = tassoc_q;
         `SIOT_A_CMD:
         begin
            rd_d[N_OUT-1:0] = out_cmd_q;
            rd_d[8 +: N_TEST] = test_cmd_q;
         end
         `SIOT_A_IN_DATA: rd_d[N_IN-1:0] = in_data_q;
         `SIOT_A_IN_STAT: rd_d[N_IN-1:0] = in_stat_q;
         `SIOT_A_OUT_STAT:
         begin
            rd_d[N_OUT-1:0] = out_stat_q;
            rd_d[8 +: N_TEST] = test_stat_q;
            rd_d[15:14] = {comb_out_q, comb_in_q};
         end
         `SIOT_A_READBACK: rd_d[N_OUT-1:0] = rback_q;
         `SIOT_A_IRQ_STAT: rd_d[`SIOT_EV_W-1:0] = irq_stat_q;
         `SIOT_A_IRQ_MASK: rd_d[`SIOT_EV_W-1:0] = irq_mask_q;
         default: rd_d = 16'h0000;
      endcase
   end

   // Read data stands one cycle after the strobe only
   always @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_o <= 16'h0000;
      else if (ce_i)
         rdata_o <= rd_i ? rd_d : 16'h0000;
   end
endmodule // siot_top

// [siot_chk.sv]
// Checker for the safety I/O status block, bound to its top module.
// Assumes one clock domain and the top module's register port.
`timescale 1ns/1ps
`include "siot_defs.vh"
module siot_chk #(
   parameter N_OUT = 4,
   parameter N_TEST = 4
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire ce_i,
   // Register port
   input wire [3:0] addr_i,
   input wire [15:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [15:0] rdata_o,
   // Outputs
   input wire [N_OUT-1:0] safe_out_o,
   input wire [N_TEST-1:0] test_out_o,
   input wire lamp_red_o,
   input wire lamp_green_o,
   input wire irq_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Safe state while the fault lamp is lit
   AST_FATAL_SAFE_OFF: assert property (
      lamp_red_o |-> safe_out_o == '0) else $error("safe out on in fault");
   AST_FATAL_TEST_OFF: assert property (
      lamp_red_o |-> test_out_o == '0) else $error("test out on in fault");
   AST_RED_STICKY: assert property (
      lamp_red_o |=> lamp_red_o) else $error("fault lamp dropped");
   AST_LAMP_EXCL: assert property (
      !(lamp_red_o && lamp_green_o)) else $error("both lamp colours on");
   // Read data stand only in the cycle after the strobe
   AST_RD_IDLE: assert property (
      $past(ce_i) && !$past(rd_i) |-> rdata_o == 16'h0000)
      else $error("read data without read");
   AST_RD_UNMAP: assert property (
      rd_i && ce_i && addr_i > 4'h9 |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   AST_IRQ_MASKED: assert property (
      wr_i && ce_i && addr_i == `SIOT_A_IRQ_MASK && wdata_i[3:0] == 4'h0
      |=> ##[0:1] !irq_o) else $error("irq high with mask clear");
   AST_DIAG_START: assert property (
      $rose(rst_n_i) |-> ##[0:4] (lamp_green_o || lamp_red_o))
      else $error("no diagnostic result after reset");
   AST_FATAL_DATA: assert property (
      lamp_red_o && rd_i && ce_i && addr_i inside {`SIOT_A_IN_DATA,
      `SIOT_A_IN_STAT, `SIOT_A_OUT_STAT} |=> rdata_o == 16'h0000)
      else $error("data or status on in fault");
   // Main scenarios reached
   cover property ($rose(lamp_red_o));
   cover property ($rose(irq_o));
   cover property (rd_i && addr_i == `SIOT_A_OUT_STAT);
endmodule // siot_chk

bind siot_top siot_chk #(.N_OUT(N_OUT), .N_TEST(N_TEST)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .safe_out_o(safe_out_o), .test_out_o(test_out_o),
   .lamp_red_o(lamp_red_o), .lamp_green_o(lamp_green_o), .irq_o(irq_o));

// [siot_field.sv]
// Field wiring model: contacts, a short to supply and load feedback.
// Assumes the bound contact is fed from its test output.
`timescale 1ns/1ps
module siot_field #(
   parameter N_IN = 8,
   parameter N_OUT = 4,
   parameter N_TEST = 4,
   parameter BIND_IN = 2,
   parameter BIND_TEST = 1
) (
   // Device outputs
   input wire [N_OUT-1:0] safe_out_i,
   input wire [N_TEST-1:0] test_out_i,
   // Field state
   input wire [N_IN-1:0] closed_i,
   input wire short_i,
   // Pins back into the device
   output logic [N_IN-1:0] in_pin_o,
   output logic [N_OUT-1:0] out_fb_o,
   output logic [N_TEST-1:0] test_fb_o
);
   // Closed contact passes the pulse; a short holds the line high
   always_comb
   begin
      in_pin_o = closed_i;
      in_pin_o[BIND_IN] = short_i | (closed_i[BIND_IN] &
         test_out_i[BIND_TEST]);
   end
   // Healthy loads read back the driven level
   assign out_fb_o = safe_out_i;
   assign test_fb_o = test_out_i;
endmodule // siot_field

// [siot_top_tb.sv]
// Self-checking bench for the safety I/O status and test-pulse block.
// Assumes short timing parameters and the field model beside the block.
`timescale 1ns/1ps
`include "siot_defs.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
   err_count++; $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module siot_top_tb;
   localparam PL = 4;
   localparam PD = 20;
   logic clk, rst_n, wr, rd, diag_err, short_in, lamp_red, lamp_green, irq;
   logic ce;
   logic [3:0] addr, out_fb, test_fb, safe_out, test_out, held;
   logic [15:0] wdata, rdata, d;
   logic [7:0] closed, in_pin;
   int err_count, total_checks, i, n0, n1, nb;
   siot_top #(.PULSE_CYC(PL), .PERIOD_CYC(PD), .DIAG_CYC(50)) dut (
      .ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .in_pin_i(in_pin), .out_fb_i(out_fb), .test_fb_i(test_fb),
      .diag_err_i(diag_err), .safe_out_o(safe_out), .test_out_o(test_out),
      .lamp_red_o(lamp_red), .lamp_green_o(lamp_green), .irq_o(irq));
   siot_field u_field (.safe_out_i(safe_out), .test_out_i(test_out),
      .closed_i(closed), .short_i(short_in), .in_pin_o(in_pin),
      .out_fb_o(out_fb), .test_fb_o(test_fb));
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tmo(input logic ok);
      if (ok !== 1'b1)
      begin
         err_count++;
         $display("BAD t=%0t wait ran out %h %h", $time, ok, 1'b1);
         stop_test;
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Power-up check, unmapped read, periodic diagnostic event
   task automatic t_diag;
      for (i = 0; i < 20 && lamp_green !== 1'b1; i++) @(posedge clk);
      tmo(lamp_green);
      rd_reg(`SIOT_A_CTRL);
      `CHK(d, 16'h0002)
      rd_reg(4'hC);
      `CHK(d, 16'h0000)
      wr_reg(`SIOT_A_IRQ_STAT, 16'h000F);
      cyc(60);
      rd_reg(`SIOT_A_IRQ_STAT);
      `CHK(d[`SIOT_EV_DIAG], 1'b1)
   endtask
   // Locked configuration refuses a mode change
   task automatic t_lock;
      wr_reg(`SIOT_A_CTRL, 16'h0001);
      rd_reg(`SIOT_A_CTRL);
      `CHK(d, 16'h0003)
      wr_reg(`SIOT_A_TMODE, 16'h0055);
      rd_reg(`SIOT_A_TMODE);
      `CHK(d, 16'h0000)
      wr_reg(`SIOT_A_CTRL, 16'h0000);
      rd_reg(`SIOT_A_CTRL);
      `CHK(d, 16'h0002)
   endtask
   // Supply, pulse and standard test outputs with status reads
   task automatic t_modes;
      wr_reg(`SIOT_A_TASSOC, 16'h0010);
      wr_reg(`SIOT_A_TMODE, 16'h00C6);
      wr_reg(`SIOT_A_CMD, 16'h0C0A);
      cyc(6);
      n0 = 0;
      n1 = 0;
      nb = 0;
      repeat (2 * PD)
      begin
         @(posedge clk);
         n0 += (test_out[0] !== 1'b1);
         n1 += (test_out[1] === 1'b0);
         nb += (test_out[3:2] !== 2'b11 || safe_out !== 4'hA);
      end
      `CHK(n0, 0)
      `CHK(n1, 2 * PL)
      `CHK(nb, 0)
      rd_reg(`SIOT_A_IN_STAT);
      `CHK(d, 16'h00FF)
      rd_reg(`SIOT_A_IN_DATA);
      `CHK((d[7:0] | 8'h04), 8'hFF)
      rd_reg(`SIOT_A_OUT_STAT);
      `CHK(d, 16'hCF0F)
      rd_reg(`SIOT_A_READBACK);
      `CHK(d[3:0], 4'hA)
      // Low clock enable freezes the pulse train and drive
      @(posedge clk);
      ce <= 1'b0;
      cyc(2);
      held = test_out;
      nb = 0;
      repeat (PD)
      begin
         @(posedge clk);
         nb += (test_out !== held);
      end
      `CHK(nb, 0)
      @(posedge clk);
      ce <= 1'b1;
   endtask
   // Short on the pulsed input, interrupt, recovery
   task automatic t_fault;
      @(posedge clk);
      short_in <= 1'b1;
      cyc(2 * PD + 8);
      rd_reg(`SIOT_A_IN_STAT);
      `CHK(d, 16'h00FB)
      rd_reg(`SIOT_A_IN_DATA);
      `CHK(d[2], 1'b0)
      rd_reg(`SIOT_A_OUT_STAT);
      `CHK(d[15:14], 2'b10)
      wr_reg(`SIOT_A_IRQ_MASK, 16'h0001);
      cyc(3);
      `CHK(irq, 1'b1)
      wr_reg(`SIOT_A_IRQ_MASK, 16'h0000);
      cyc(3);
      `CHK(irq, 1'b0)
      rd_reg(`SIOT_A_IRQ_STAT);
      `CHK(d[`SIOT_EV_IN_FAULT], 1'b1)
      @(posedge clk);
      short_in <= 1'b0;
      closed <= 8'hFB;
      cyc(2 * PD);
      rd_reg(`SIOT_A_IN_STAT);
      `CHK(d, 16'h00FF)
   endtask
   // Internal error forces everything off
   task automatic t_fatal;
      @(posedge clk);
      closed <= 8'hFF;
      diag_err <= 1'b1;
      for (i = 0; i < 120 && lamp_red !== 1'b1; i++) @(posedge clk);
      tmo(lamp_red);
      cyc(2);
      `CHK(({safe_out, test_out, lamp_green}), 9'h000)
      rd_reg(`SIOT_A_IN_DATA);
      `CHK(d, 16'h0000)
      rd_reg(`SIOT_A_IN_STAT);
      `CHK(d, 16'h0000)
      rd_reg(`SIOT_A_OUT_STAT);
      `CHK(d, 16'h0000)
      rd_reg(`SIOT_A_CTRL);
      `CHK(d[`SIOT_CTRL_FATAL], 1'b1)
   endtask
   // Main sequence
   initial
   begin
      err_count = 0;
      total_checks = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      diag_err = 1'b0;
      short_in = 1'b0;
      closed = 8'hFF;
      cyc(6);
      rst_n <= 1'b1;
      t_diag;
      t_lock;
      t_modes;
      t_fault;
      t_fatal;
      stop_test;
   end
endmodule // siot_top_tb
